// ---- rtl/lin_ctrl_pkg.sv ----
package lin_ctrl_pkg;
	// chip power modes, driven by the power mode manager outside
	typedef enum logic [2:0] {
		CHIP_NORMAL   = 3'h0,
		CHIP_STOP     = 3'h1,
		CHIP_SLEEP    = 3'h2,
		CHIP_RESTART  = 3'h3,
		CHIP_FAILSAFE = 3'h4
	} chip_mode_t;

	// lin_mode_field codes; wake capable is fixed at 01
	typedef enum logic [1:0] {
		LIN_OFF    = 2'h0,
		LIN_WAKE   = 2'h1,
		LIN_NORMAL = 2'h2,
		LIN_RXONLY = 2'h3
	} lin_mode_t;

	typedef struct packed {
		logic low_slope;
		logic flash_prog;
	} slope_cfg_t;

	localparam slope_cfg_t SLOPE_CFG_RST = 2'h0;

	localparam int CLK_MHZ            = 20;
	localparam int CLK_HZ             = CLK_MHZ * 1000000;
	localparam int WAKE_FILTER_US     = 30;
	localparam int ENABLE_TIME_US     = 10;
	localparam int TX_TIMEOUT_MS      = 12;
	localparam int BUS_CLAMP_MS       = 12;
	localparam int BAUD_NORMAL        = 20000;
	localparam int BAUD_LOW_X10       = 104000;
	localparam int BAUD_FLASH         = 115000;
	// least times round up, all time figures are whole here; bit lengths truncate
	localparam int WAKE_FILTER_CYC    = WAKE_FILTER_US * CLK_MHZ;
	localparam int ENABLE_CYC         = ENABLE_TIME_US * CLK_MHZ;
	localparam int TX_TIMEOUT_CYC     = TX_TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int BUS_CLAMP_CYC      = BUS_CLAMP_MS * CLK_MHZ * 1000;
	localparam int BIT_NORMAL_CYC     = CLK_HZ / BAUD_NORMAL;
	localparam int BIT_LOW_CYC        = (CLK_HZ * 10) / BAUD_LOW_X10;
	localparam int BIT_FLASH_CYC      = CLK_HZ / BAUD_FLASH;
	localparam int CNT_W              = 20;
	localparam int FIFO_DEPTH         = 8;
endpackage

// ---- rtl/lin_transceiver_mode_control.sv ----
// What this block does
// [R1] after reset mode is off, allowed in all chip modes; off ignores wakes
// [R2] normal mode selectable by spi only in chip normal or stop mode
// [R3] normal mode drives bus from transmit data, returns bus level on receive
// [R4] controller keeps transmit recessive until enabling time has elapsed
// [R5] early dominant is suppressed; only next dominant after enabling goes out
// [R6] receive-only disables driver, keeps receiver; only in chip normal or stop
// [R7] wake capable selectable in stop/sleep/restart/normal; forced on fail-safe
// [R8] dominant longer than wake filter wakes; receive low until mode changes or chip enters fail-safe
// [R9] after wake, mode field still reads wake capable, detection disarmed
// [R10] rearm only after switching to normal, receive-only or off first
// [R11] rearm automatically on entering chip stop, sleep or fail-safe
// [R12] wake in stop/normal: interrupt low, wake status set, receive low
// [R13] controller must itself move chip from stop to normal after wake
// [R14] wake in stop enables watchdog if disabled and configured to do so
// [R15] wake in sleep/fail-safe/restart requests restart; receive low, no interrupt
// [R16] transmit dominant past time-out: driver off, bus recessive, fault set
// [R17] transmitter resumes once time-out cause removed; config untouched
// [R18] bus dominant past clamp time in any mode sets fault, config untouched
// [R19] bus supply under-voltage disables driver and receiver; config kept
// [R20] default normal slope; low-slope bit changes only transmitter slew
// [R21] low-slope writable in chip normal only, applied when chip select rises
// [R22] flash bit in chip normal disables slope control, applied on select rise
// [R23] wake filter accepts dominant after 30 us, inside the 30 to 150 range
// [R24] mode field is two bits with wake capable coded 01
// [R25] fault flag sticks until software clears it
`timescale 1ns/100ps
`default_nettype none

module lin_tx_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	output logic      [WIDTH-1:0] out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("lin_tx_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_out  = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_data_out  = store[rd_ptr];

	always_ff @(posedge core_clk_in) begin
		if (push) begin
			store[wr_ptr] <= in_data_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
			count  <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

module lin_transceiver_mode_control #(
	parameter int TX_TIMEOUT = lin_ctrl_pkg::TX_TIMEOUT_CYC,
	parameter int BUS_CLAMP  = lin_ctrl_pkg::BUS_CLAMP_CYC
) (
	input  wire logic                     core_clk_in,
	input  wire logic                     sys_rst_in,
	input  wire lin_ctrl_pkg::chip_mode_t chip_mode_in,
	input  wire logic                     mode_wr_in,
	input  wire lin_ctrl_pkg::lin_mode_t  mode_wdata_in,
	input  wire logic                     slope_wr_in,
	input  wire lin_ctrl_pkg::slope_cfg_t slope_wdata_in,
	input  wire logic                     spi_csn_in,
	input  wire logic                     wdog_on_bus_wake_in,
	input  wire logic                     wdog_enabled_in,
	input  wire logic                     wake_status_clear_in,
	input  wire logic                     fault_clear_in,
	input  wire logic                     lin_transmit_in,
	input  wire logic                     tx_valid_in,
	output logic                          tx_ready_out,
	input  wire logic                     bus_dominant_in,
	input  wire logic                     bus_supply_uv_in,
	output lin_ctrl_pkg::lin_mode_t       lin_mode_field_out,
	output lin_ctrl_pkg::slope_cfg_t      slope_cfg_out,
	output logic                          drive_dominant_out,
	output logic                          driver_enable_out,
	output logic                          receiver_enable_out,
	output logic                          lin_receive_out,
	output logic                          int_n_out,
	output logic                          wake_status_reg_out,
	output logic                          lin_fault_flag_out,
	output logic                          wake_armed_out,
	output logic                          restart_req_out,
	output logic                          wdog_enable_out
);
	import lin_ctrl_pkg::*;

	generate
		if (TX_TIMEOUT < 1 || TX_TIMEOUT >= (1 << CNT_W) ||
		    BUS_CLAMP < 1 || BUS_CLAMP >= (1 << CNT_W)) begin : g_bad_cnt
			$error("time-out counts must fit the counter width");
		end
	endgenerate

	localparam logic [CNT_W-1:0] TX_TO_C = CNT_W'(TX_TIMEOUT);
	localparam logic [CNT_W-1:0] CLAMP_C = CNT_W'(BUS_CLAMP);
	localparam logic [CNT_W-1:0] WAKE_C  = CNT_W'(WAKE_FILTER_CYC);
	localparam logic [CNT_W-1:0] EN_C    = CNT_W'(ENABLE_CYC);

	// which modes software may pick in the current chip mode
	function automatic logic mode_allowed(input lin_mode_t m,
	                                      input chip_mode_t c);
		case (m)
			LIN_OFF:    mode_allowed = 1'b1;
			LIN_NORMAL: mode_allowed = (c == CHIP_NORMAL) || (c == CHIP_STOP);
			LIN_RXONLY: mode_allowed = (c == CHIP_NORMAL) || (c == CHIP_STOP);
			LIN_WAKE:   mode_allowed = (c != CHIP_FAILSAFE);
			default:    mode_allowed = 1'b0;
		endcase
	endfunction

	lin_mode_t        mode;
	chip_mode_t       chip_prev;
	slope_cfg_t       slope_pend;
	logic             slope_pend_valid;
	logic             csn_prev;
	logic             armed;
	logic             wake_rx_low;
	logic             wake_event;
	logic             chip_entry;
	logic             mode_take;
	logic [CNT_W-1:0] wake_cnt;
	logic [CNT_W-1:0] en_cnt;
	logic             en_done;
	logic             tx_allowed;
	logic [CNT_W-1:0] bit_cnt;
	logic [CNT_W-1:0] bit_len;
	logic             bit_tick;
	logic             cur_bit;
	logic             fifo_bit;
	logic             fifo_valid;
	logic             fifo_pop;
	logic [CNT_W-1:0] tx_dom_cnt;
	logic             tx_timed_out;
	logic [CNT_W-1:0] bus_dom_cnt;
	logic             clamp_hit;
	logic             next_drive;
	logic             int_pending;

	assign mode_take  = mode_wr_in && mode_allowed(mode_wdata_in, chip_mode_in);
	assign chip_entry = (chip_mode_in != chip_prev);
	// [R8] wake filter
	assign wake_event = (mode == LIN_WAKE) && armed && !bus_supply_uv_in &&
	                    bus_dominant_in && (wake_cnt == WAKE_C);

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			chip_prev <= CHIP_NORMAL;
			csn_prev  <= 1'b1;
		end else begin
			chip_prev <= chip_mode_in;
			csn_prev  <= spi_csn_in;
		end
	end

	// [R1] off after reset
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			mode <= LIN_OFF;
		end else if (chip_entry && chip_mode_in == CHIP_FAILSAFE) begin
			// [R7] forced wake capable
			mode <= LIN_WAKE;
		end else if (mode_take) begin
			// [R2] [R6] [R7] gated by chip mode
			mode <= mode_wdata_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			armed <= 1'b1;
		end else if (chip_entry && (chip_mode_in == CHIP_STOP ||
		         chip_mode_in == CHIP_SLEEP || chip_mode_in == CHIP_FAILSAFE)) begin
			// [R11] rearm on entry
			armed <= 1'b1;
		end else if (mode_take && mode_wdata_in != LIN_WAKE) begin
			// [R10] toggle rearms
			armed <= 1'b1;
		end else if (wake_event) begin
			// [R9] disarm, mode code kept
			armed <= 1'b0;
		end
	end

	// [R23] saturating filter count, runs whether armed or not
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || !bus_dominant_in || mode != LIN_WAKE) begin
			wake_cnt <= '0;
		end else if (wake_cnt != WAKE_C) begin
			wake_cnt <= wake_cnt + 1'b1;
		end
	end

	// [R8] receive held low until another mode is chosen or fail-safe is entered
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wake_rx_low <= 1'b0;
		end else if (wake_event) begin
			wake_rx_low <= 1'b1;
		end else if (mode_take && mode_wdata_in != LIN_WAKE) begin
			wake_rx_low <= 1'b0;
		end else if (chip_entry && chip_mode_in == CHIP_FAILSAFE) begin
			wake_rx_low <= 1'b0;
		end
	end

	// [R12] status and interrupt; set beats clear
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wake_status_reg_out <= 1'b0;
			int_pending         <= 1'b0;
		end else begin
			if (wake_event) begin
				wake_status_reg_out <= 1'b1;
			end else if (wake_status_clear_in) begin
				wake_status_reg_out <= 1'b0;
			end
			if (wake_event && (chip_mode_in == CHIP_STOP ||
			    chip_mode_in == CHIP_NORMAL)) begin
				int_pending <= 1'b1;
			end else if (wake_status_clear_in) begin
				int_pending <= 1'b0;
			end
		end
	end

	// [R14] [R15] one-cycle requests to the power mode manager
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			restart_req_out <= 1'b0;
			wdog_enable_out <= 1'b0;
		end else begin
			restart_req_out <= wake_event && (chip_mode_in == CHIP_SLEEP ||
			                   chip_mode_in == CHIP_FAILSAFE ||
			                   chip_mode_in == CHIP_RESTART);
			wdog_enable_out <= wake_event && chip_mode_in == CHIP_STOP &&
			                   wdog_on_bus_wake_in && !wdog_enabled_in;
		end
	end

	// [R21] [R22] staged in chip normal, applied on chip select rise
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			slope_cfg_out    <= SLOPE_CFG_RST;
			slope_pend       <= SLOPE_CFG_RST;
			slope_pend_valid <= 1'b0;
		end else if (spi_csn_in && !csn_prev && slope_pend_valid) begin
			slope_cfg_out    <= slope_pend;
			slope_pend_valid <= 1'b0;
		end else if (slope_wr_in && chip_mode_in == CHIP_NORMAL) begin
			slope_pend       <= slope_wdata_in;
			slope_pend_valid <= 1'b1;
		end
	end

	// [R20] slope only sets the bit pacing of the transmit path
	always_comb begin
		if (slope_cfg_out.flash_prog) begin
			bit_len = CNT_W'(BIT_FLASH_CYC);
		end else if (slope_cfg_out.low_slope) begin
			bit_len = CNT_W'(BIT_LOW_CYC);
		end else begin
			bit_len = CNT_W'(BIT_NORMAL_CYC);
		end
	end

	// enabling time restarts whenever normal mode is left
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || mode != LIN_NORMAL) begin
			en_cnt <= '0;
		end else if (!en_done) begin
			en_cnt <= en_cnt + 1'b1;
		end
	end
	assign en_done = (en_cnt == EN_C);

	// [R5] dominant only after a recessive seen past enabling
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || mode != LIN_NORMAL) begin
			tx_allowed <= 1'b0;
		end else if (en_done && cur_bit) begin
			tx_allowed <= 1'b1;
		end
	end

	// bit pacing; fifo stalls outside normal mode so the source sees it
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || mode != LIN_NORMAL || bit_tick) begin
			bit_cnt <= '0;
		end else begin
			bit_cnt <= bit_cnt + 1'b1;
		end
	end
	assign bit_tick = (mode == LIN_NORMAL) && (bit_cnt == bit_len - 1'b1);
	assign fifo_pop = bit_tick;

	// [R3] current transmit bit, recessive when starved
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || mode != LIN_NORMAL) begin
			cur_bit <= 1'b1;
		end else if (bit_tick) begin
			cur_bit <= fifo_valid ? fifo_bit : 1'b1;
		end
	end

	lin_tx_fifo #(
		.WIDTH (1),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.core_clk_in   (core_clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_data_in    (lin_transmit_in),
		.in_valid_in   (tx_valid_in),
		.in_ready_out  (tx_ready_out),
		.out_data_out  (fifo_bit),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop)
	);

	// [R16] [R17] time-out lifts when the dominant request ends
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || cur_bit) begin
			tx_dom_cnt   <= '0;
			tx_timed_out <= 1'b0;
		end else if (tx_dom_cnt == TX_TO_C) begin
			tx_timed_out <= 1'b1;
		end else begin
			tx_dom_cnt <= tx_dom_cnt + 1'b1;
		end
	end

	// [R18] clamp watch runs in every mode
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || !bus_dominant_in) begin
			bus_dom_cnt <= '0;
		end else if (bus_dom_cnt != CLAMP_C) begin
			bus_dom_cnt <= bus_dom_cnt + 1'b1;
		end
	end
	assign clamp_hit = bus_dominant_in && (bus_dom_cnt == CLAMP_C - 1'b1);

	// [R25] sticky fault, set beats clear
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			lin_fault_flag_out <= 1'b0;
		end else if (clamp_hit || (tx_dom_cnt == TX_TO_C && !cur_bit)) begin
			lin_fault_flag_out <= 1'b1;
		end else if (fault_clear_in) begin
			lin_fault_flag_out <= 1'b0;
		end
	end

	// [R19] supply loss blanks both stages
	assign next_drive = (mode == LIN_NORMAL) && tx_allowed && !cur_bit &&
	                    !tx_timed_out && !bus_supply_uv_in;

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			drive_dominant_out  <= 1'b0;
			driver_enable_out   <= 1'b0;
			receiver_enable_out <= 1'b0;
			lin_receive_out     <= 1'b1;
		end else begin
			// [R3] [R6] driver only in normal mode
			drive_dominant_out  <= next_drive;
			driver_enable_out   <= (mode == LIN_NORMAL) && !bus_supply_uv_in &&
			                       !tx_timed_out;
			receiver_enable_out <= (mode == LIN_NORMAL || mode == LIN_RXONLY) &&
			                       !bus_supply_uv_in;
			if (wake_rx_low || wake_event) begin
				lin_receive_out <= 1'b0;
			end else if ((mode == LIN_NORMAL || mode == LIN_RXONLY) &&
			             !bus_supply_uv_in) begin
				lin_receive_out <= !bus_dominant_in;
			end else begin
				lin_receive_out <= 1'b1;
			end
		end
	end

	// [R24] two-bit field, wake capable reads 01
	assign lin_mode_field_out = mode;
	assign int_n_out          = !int_pending;
	assign wake_armed_out     = armed;
endmodule

`default_nettype wire

// ---- verif/lin_ctrl_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module lin_ctrl_checker
	import lin_ctrl_pkg::*;
(
	input wire logic                     core_clk_in,
	input wire logic                     sys_rst_in,
	input wire lin_ctrl_pkg::chip_mode_t chip_mode_in,
	input wire logic                     mode_wr_in,
	input wire lin_ctrl_pkg::lin_mode_t  mode_wdata_in,
	input wire logic                     spi_csn_in,
	input wire logic                     fault_clear_in,
	input wire logic                     bus_supply_uv_in,
	input wire lin_ctrl_pkg::lin_mode_t  lin_mode_field_out,
	input wire lin_ctrl_pkg::slope_cfg_t slope_cfg_out,
	input wire logic                     driver_enable_out,
	input wire logic                     receiver_enable_out,
	input wire logic                     lin_receive_out,
	input wire logic                     int_n_out,
	input wire logic                     wake_status_reg_out,
	input wire logic                     lin_fault_flag_out,
	input wire logic                     wake_armed_out,
	input wire logic                     restart_req_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	property p_mode_taken;
		mode_wr_in && chip_mode_in inside {CHIP_NORMAL, CHIP_STOP}
		|=> lin_mode_field_out == $past(mode_wdata_in);
	endproperty
	a_mode_taken: assert property (p_mode_taken)
		else $error("mode write lost");

	property p_mode_refused;
		mode_wr_in && chip_mode_in inside {CHIP_SLEEP, CHIP_RESTART}
		&& mode_wdata_in inside {LIN_NORMAL, LIN_RXONLY}
		|=> $stable(lin_mode_field_out);
	endproperty
	a_mode_refused: assert property (p_mode_refused)
		else $error("mode write not refused");

	// only writes and fail-safe entry may touch the mode field
	property p_cfg_kept;
		!mode_wr_in && chip_mode_in != CHIP_FAILSAFE
		|=> $stable(lin_mode_field_out);
	endproperty
	a_cfg_kept: assert property (p_cfg_kept)
		else $error("mode field changed by itself");

	property p_wake_ind;
		$rose(wake_status_reg_out) |-> !lin_receive_out
		&& !wake_armed_out && lin_mode_field_out == LIN_WAKE;
	endproperty
	a_wake_ind: assert property (p_wake_ind)
		else $error("wake indication wrong");

	property p_int_wake;
		$rose(wake_status_reg_out)
		&& $past(chip_mode_in) inside {CHIP_NORMAL, CHIP_STOP} |-> !int_n_out;
	endproperty
	a_int_wake: assert property (p_int_wake)
		else $error("no interrupt on wake");

	property p_no_int;
		$rose(wake_status_reg_out)
		&& $past(chip_mode_in) inside {CHIP_SLEEP, CHIP_RESTART, CHIP_FAILSAFE}
		|-> restart_req_out && $stable(int_n_out);
	endproperty
	a_no_int: assert property (p_no_int)
		else $error("sleep wake handling wrong");

	property p_uv;
		bus_supply_uv_in |=> !driver_enable_out && !receiver_enable_out;
	endproperty
	a_uv: assert property (p_uv)
		else $error("stages on in under-voltage");

	property p_fault_hold;
		lin_fault_flag_out && !fault_clear_in |=> lin_fault_flag_out;
	endproperty
	a_fault_hold: assert property (p_fault_hold)
		else $error("fault flag dropped");

	// staged slope must wait for the select to return high
	property p_slope;
		!spi_csn_in |=> $stable(slope_cfg_out);
	endproperty
	a_slope: assert property (p_slope)
		else $error("slope applied early");
endmodule
`default_nettype wire

// ---- verif/lin_mcu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module lin_mcu_model (
	input  wire logic core_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic send_in,
	input  wire logic bit_in,
	input  wire logic ready_in,
	output logic      tx_bit_out,
	output logic      tx_valid_out
);
	logic taken;

	always_ff @(posedge core_clk_in) begin
		taken <= !sys_rst_in && tx_valid_out && ready_in;
	end

	// held until the rising edge that sees ready
	always_ff @(negedge core_clk_in) begin
		if (sys_rst_in) begin
			tx_valid_out <= 1'b0;
			tx_bit_out <= 1'b1;
		end else if (taken) begin
			tx_valid_out <= 1'b0;
			// released line must not keep the old bit
			tx_bit_out <= ~tx_bit_out;
		end else if (send_in && !tx_valid_out) begin
			tx_valid_out <= 1'b1;
			tx_bit_out <= bit_in;
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb_lin_transceiver_mode_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_lin_transceiver_mode_control;
	import lin_ctrl_pkg::*;
	logic core_clk_in, sys_rst_in, mode_wr_in, slope_wr_in, spi_csn_in;
	logic wdog_on_bus_wake_in, wdog_enabled_in, wake_status_clear_in;
	logic fault_clear_in, lin_transmit_in, tx_valid_in, tx_ready_out;
	logic bus_dominant_in, bus_supply_uv_in, drive_dominant_out;
	logic driver_enable_out, receiver_enable_out, lin_receive_out;
	logic int_n_out, wake_status_reg_out, lin_fault_flag_out;
	logic wake_armed_out, restart_req_out, wdog_enable_out;
	logic bus_force, send, send_bit;
	// bit 1 restart request seen, bit 0 watchdog request seen
	logic [1:0] seen;
	chip_mode_t chip_mode_in;
	lin_mode_t  mode_wdata_in, lin_mode_field_out;
	slope_cfg_t slope_wdata_in, slope_cfg_out;
	int         fails, cmp_count, i;

	// single wire: either side may pull it dominant
	assign bus_dominant_in = drive_dominant_out | bus_force;
	always #25 core_clk_in = ~core_clk_in;

	// short time-outs keep the run brief
	lin_transceiver_mode_control #(
		.TX_TIMEOUT(3000),
		.BUS_CLAMP(5000)
	) dut (.*);

	lin_mcu_model mcu (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.send_in     (send),
		.bit_in      (send_bit),
		.ready_in    (tx_ready_out),
		.tx_bit_out  (lin_transmit_in),
		.tx_valid_out(tx_valid_in)
	);

	task chk(input logic [1:0] got, input logic [1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task tmo(input logic ok);
		if (!ok) begin
			fails++;
			$display("unexpected at %0t: got 0 exp 1", $time);
			end_sim;
		end
	endtask

	task cyc(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask

	task set_mode(input lin_mode_t m);
		mode_wdata_in = m;
		mode_wr_in = 1'b1;
		cyc(1);
		mode_wr_in = 1'b0;
		cyc(2);
	endtask

	task bus_dom(input int n);
		bus_force = 1'b1;
		seen = 2'h0;
		repeat (n) begin
			cyc(1);
			seen = seen | {restart_req_out, wdog_enable_out};
		end
		bus_force = 1'b0;
		cyc(2);
	endtask

	task stage(input slope_cfg_t s);
		slope_wdata_in = s;
		slope_wr_in = 1'b1;
		cyc(1);
		slope_wr_in = 1'b0;
		cyc(3);
	endtask

	task csn;
		spi_csn_in = 1'b0;
		cyc(2);
		spi_csn_in = 1'b1;
		cyc(3);
	endtask

	task push(input logic b);
		for (i = 0; i < 20000 && tx_valid_in; i++) cyc(1);
		tmo(!tx_valid_in);
		send <= 1'b1;
		send_bit <= b;
		cyc(1);
		send <= 1'b0;
		cyc(2);
	endtask

	initial begin
		core_clk_in = 1'b0;
		sys_rst_in = 1'b1;
		chip_mode_in = CHIP_NORMAL;
		{mode_wr_in, slope_wr_in, fault_clear_in} = 3'h0;
		mode_wdata_in = LIN_OFF;
		slope_wdata_in = 2'h0;
		{spi_csn_in, wdog_on_bus_wake_in, wdog_enabled_in} = 3'h6;
		{wake_status_clear_in, bus_supply_uv_in, bus_force} = 3'h0;
		{send, send_bit} = 2'h1;
		fails = 0;
		cmp_count = 0;
		cyc(20);
		sys_rst_in = 1'b0;
		cyc(1);
		chk(lin_mode_field_out, LIN_OFF);
		chk({int_n_out, lin_receive_out}, 2'h3);
		chk({wake_status_reg_out, lin_fault_flag_out}, 2'h0);
		chk(slope_cfg_out, 2'h0);
		$display("done reset");
		bus_dom(5100);
		chk({wake_status_reg_out, lin_receive_out}, 2'h1);
		chk({lin_fault_flag_out, 1'b0}, 2'h2);
		chk(lin_mode_field_out, LIN_OFF);
		fault_clear_in = 1'b1;
		cyc(1);
		fault_clear_in = 1'b0;
		cyc(1);
		chk({1'b0, lin_fault_flag_out}, 2'h0);
		$display("done off and clamp");
		chip_mode_in = CHIP_SLEEP;
		cyc(2);
		set_mode(LIN_NORMAL);
		chk(lin_mode_field_out, LIN_OFF);
		set_mode(LIN_RXONLY);
		chk(lin_mode_field_out, LIN_OFF);
		chip_mode_in = CHIP_STOP;
		cyc(2);
		set_mode(LIN_RXONLY);
		chk(lin_mode_field_out, LIN_RXONLY);
		chk({driver_enable_out, receiver_enable_out}, 2'h1);
		set_mode(LIN_WAKE);
		// 25 us dominant is below the wake filter
		bus_dom(500);
		chk({wake_status_reg_out, wake_armed_out}, 2'h1);
		bus_dom(700);
		chk(lin_mode_field_out, LIN_WAKE);
		chk({wake_armed_out, lin_receive_out}, 2'h0);
		chk({int_n_out, wake_status_reg_out}, 2'h1);
		chk(seen, 2'h1);
		wake_status_clear_in = 1'b1;
		cyc(1);
		wake_status_clear_in = 1'b0;
		set_mode(LIN_WAKE);
		chk({int_n_out, wake_armed_out}, 2'h2);
		// the controller returns the chip to normal itself
		chip_mode_in = CHIP_NORMAL;
		set_mode(LIN_OFF);
		chk({wake_armed_out, lin_receive_out}, 2'h3);
		set_mode(LIN_WAKE);
		chip_mode_in = CHIP_SLEEP;
		cyc(2);
		bus_dom(700);
		chk({int_n_out, lin_receive_out}, 2'h2);
		chk(seen, 2'h2);
		chip_mode_in = CHIP_RESTART;
		cyc(2);
		chk({1'b0, wake_armed_out}, 2'h0);
		chip_mode_in = CHIP_STOP;
		cyc(2);
		chk({1'b0, wake_armed_out}, 2'h1);
		chip_mode_in = CHIP_NORMAL;
		set_mode(LIN_OFF);
		chip_mode_in = CHIP_FAILSAFE;
		cyc(2);
		chk(lin_mode_field_out, LIN_WAKE);
		$display("done wake");
		chip_mode_in = CHIP_STOP;
		stage(2'h2);
		csn;
		chk(slope_cfg_out, 2'h0);
		chip_mode_in = CHIP_NORMAL;
		stage(2'h2);
		chk(slope_cfg_out, 2'h0);
		csn;
		chk(slope_cfg_out, 2'h2);
		stage(2'h1);
		csn;
		chk(slope_cfg_out, 2'h1);
		stage(2'h0);
		csn;
		chk(slope_cfg_out, 2'h0);
		$display("done slope");
		set_mode(LIN_OFF);
		// off mode holds the bits, so the buffer fills
		repeat (8) push(1'b1);
		chk({1'b0, tx_ready_out}, 2'h0);
		set_mode(LIN_NORMAL);
		bus_supply_uv_in = 1'b1;
		cyc(2);
		chk({driver_enable_out, receiver_enable_out}, 2'h0);
		bus_supply_uv_in = 1'b0;
		cyc(3);
		chk(lin_mode_field_out, LIN_NORMAL);
		chk({driver_enable_out, receiver_enable_out}, 2'h3);
		// no dominant before the enabling time
		cyc(ENABLE_CYC);
		repeat (4) push(1'b0);
		for (i = 0; i < 12000 && !drive_dominant_out; i++) cyc(1);
		tmo(drive_dominant_out);
		cyc(20);
		chk({1'b0, lin_receive_out}, 2'h0);
		for (i = 0; i < 4000 && !lin_fault_flag_out; i++) cyc(1);
		tmo(lin_fault_flag_out);
		cyc(2);
		chk({drive_dominant_out, lin_fault_flag_out}, 2'h1);
		chk({driver_enable_out, lin_fault_flag_out}, 2'h1);
		chk(lin_mode_field_out, LIN_NORMAL);
		// dominant bits run out, so the time-out lifts
		for (i = 0; i < 2000 && !driver_enable_out; i++) cyc(1);
		tmo(driver_enable_out);
		chk({driver_enable_out, drive_dominant_out}, 2'h2);
		chk(lin_mode_field_out, LIN_NORMAL);
		$display("done transmit");
		end_sim;
	end
endmodule

bind lin_transceiver_mode_control lin_ctrl_checker chk_i (.*);
`default_nettype wire
